/* File: core/ssr_params.svh */
// Constants of the status and service-request block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// Status byte bit positions
`define SSR_BIT_SYNTAX   0
`define SSR_BIT_DREADY   1
`define SSR_BIT_KEY      2
`define SSR_BIT_OPDONE   3
`define SSR_BIT_LIMIT    4
`define SSR_BIT_SPARE5   5
`define SSR_BIT_RQS      6
`define SSR_BIT_SPARE7   7
`define SSR_STATUS_RESET 8'h00

// Zero-reference position
`define SSR_ZREF_W       10
`define SSR_ZREF_DEFAULT 10'h1F4
`define SSR_ZREF_MAX     10'h3FF

// Binary trace-memory transfer
`define SSR_FLAG_WORD    16'hFFFF
`define SSR_TRACE_WORDS  10'h3E9
`define SSR_TRACE_LAST   10'h3E8

// Bus address and poll pin group
`define SSR_ADDR_W       5
`define SSR_PIN_W        7

`endif

/* File: core/ssr_pkg.sv */
// Types of the status and service-request block.
// Assumes ssr_params.svh is on the include path.
`include "ssr_params.svh"

package ssr_pkg;

	typedef enum logic [1:0] {SSR_SW_CONT, SSR_SW_SINGLE, SSR_SW_MANUAL} ssr_sweep_t;
	typedef enum logic [1:0] {SSR_LIM_OFF, SSR_LIM_SILENT, SSR_LIM_REQ} ssr_limit_t;
	typedef enum logic [1:0] {SSR_DMP_IDLE, SSR_DMP_FLAG, SSR_DMP_DATA, SSR_DMP_EXT} ssr_dump_t;

	// One-cycle command pulses from the command parser
	typedef struct packed {
		logic instrument_preset;
		logic opdone_request_on;
		logic opdone_request_off;
		logic limit_test_with_request;
		logic limit_test_silent;
		logic limit_test_off;
		logic key_echo_with_request;
		logic key_echo_clear;
		logic sweep_continuous_select;
		logic sweep_single_select;
		logic sweep_manual_select;
		logic knob_manual_frequency;
		logic trace_a_clear;
		logic state_recall;
		logic plot_command;
		logic plot_marker_command;
		logic extended_status_dump;
		logic trace_memory_dump;
		logic trace_memory_load;
		logic zero_ref_write;
	} ssr_cmd_t;

	// Condition levels from the measurement engines
	typedef struct packed {
		logic syntax_error;
		logic data_ready;
		logic key_pressed;
		logic sweep_end;
		logic meas_done;
		logic plot_done;
		logic limit_fail;
	} ssr_cond_t;

	typedef struct packed {
		logic [7:0]             status;
		logic [4:0]             cond_prev;
		logic                   opdone_en;
		ssr_limit_t             limit_mode;
		logic                   key_echo_req;
		ssr_sweep_t             sweep_mode;
		logic                   sweep_restart;
		logic [`SSR_ZREF_W-1:0] zero_ref;
		logic [`SSR_ZREF_W-1:0] draw_ref;
		logic                   poll_sel;
		logic [7:0]             dio;
		logic                   dio_oe;
		logic                   data_pend;
		logic                   data_go;
		ssr_dump_t              dump;
		logic [3:0]             mem_reg;
		logic [9:0]             idx;
		logic [15:0]            tx_word;
		logic                   tx_valid;
		logic                   load_act;
		logic                   flag_seen;
		logic [9:0]             widx;
		logic                   wr_en;
		logic [9:0]             wr_addr;
		logic [15:0]            wr_data;
	} ssr_state_t;

endpackage

/* File: core/ssr_sync.sv */
// Two-flop synchroniser for a group of bus pins.
// Assumes each bit is quasi-static while it is used as a group.
`timescale 1ns/100ps
`default_nettype none

module ssr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,  // System clock
	input  wire logic         rst_b,    // Async reset, active low
	input  wire logic [W-1:0] pin_in,   // Raw pin levels
	output logic      [W-1:0] sync_out  // Synchronised levels
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

`default_nettype wire

/* File: core/ssr_top.sv */
// Status byte, service request and side registers of the instrument.
// Assumes commands arrive as one-cycle pulses on clk_sys, conditions are
// levels on clk_sys, and poll pins come straight from the bus.
`timescale 1ns/100ps
`default_nettype none
`include "ssr_params.svh"

module ssr_top
	import ssr_pkg::*;
(
	input  wire logic                   clk_sys,          // System clock 100 MHz
	input  wire logic                   rst_b,            // Async reset, active low
	input  wire ssr_cmd_t               cmd,              // Command pulses
	input  wire ssr_cond_t              cond,             // Condition levels
	input  wire logic [`SSR_ZREF_W-1:0] zero_ref_in,      // Value with zero_ref_write
	input  wire logic [`SSR_ZREF_W-1:0] recall_zero_ref,  // Value with state_recall
	input  wire logic                   draw_start,       // Drawing of an item begins
	input  wire logic                   autorange_busy,   // Autorange in progress
	input  wire logic                   data_req,         // Triggered data request
	input  wire logic                   marker_valid,     // Marker value valid
	input  wire logic [`SSR_ADDR_W-1:0] my_addr,          // Configured bus address
	input  wire logic                   spoll_pin,        // Serial poll mode pin
	input  wire logic                   talk_pin,         // Addressed to talk pin
	input  wire logic [`SSR_ADDR_W-1:0] poll_addr_pin,    // Polled address pins
	output logic                        srq_out,          // Service request, high
	output logic [7:0]                  dio_out,          // Bus data out
	output logic                        dio_oe,           // Bus data drive enable
	output logic [7:0]                  status_byte,      // Status byte view
	output logic [`SSR_ZREF_W-1:0]      zero_ref,         // Zero reference, saved
	output logic [`SSR_ZREF_W-1:0]      draw_zero_ref,    // Reference for drawing
	output logic                        limit_test_en,    // Limit testing on
	output ssr_sweep_t                  sweep_mode,       // Selected sweep mode
	output logic                        sweep_restart,    // Restart pulse
	output logic                        data_go,          // Answer triggered data
	output logic [3:0]                  mem_reg,          // Trace register 0-9
	output logic [9:0]                  mem_rd_idx,       // Trace read index
	input  wire logic [15:0]            mem_rd_data,      // Same-cycle read data
	output logic                        mem_wr_en,        // Trace write pulse
	output logic [9:0]                  mem_wr_idx,       // Trace write index
	output logic [15:0]                 mem_wr_data,      // Trace write data
	output logic [15:0]                 tx_word,          // Outgoing word
	output logic                        tx_valid,         // Outgoing word valid
	input  wire logic                   tx_ready,         // Bus takes the word
	input  wire logic [15:0]            rx_word,          // Incoming word
	input  wire logic                   rx_valid,         // Incoming word valid
	output logic                        rx_ready          // Load accepts the word
);

	function automatic logic [7:0] ssr_bit(input int pos);
		ssr_bit = 8'h01 << pos;
	endfunction

	function automatic logic rise(input logic now, input logic prev);
		rise = now & ~prev;
	endfunction

	ssr_state_t s_q;
	ssr_state_t s_d;

	logic [`SSR_PIN_W-1:0] pins_s;
	logic                  spoll_s;
	logic                  talk_s;
	logic [`SSR_ADDR_W-1:0] addr_s;
	logic                  poll_win;
	logic                  poll_done;
	logic                  op_cond;
	logic [4:0]            cond_now;
	logic [4:0]            cond_rise;
	logic [7:0]            set_bits;
	logic                  clr_op_lim;

	ssr_sync #(
		.W (`SSR_PIN_W)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.pin_in   ({spoll_pin, talk_pin, poll_addr_pin}),
		.sync_out (pins_s)
	);

	assign spoll_s  = pins_s[`SSR_PIN_W-1];
	assign talk_s   = pins_s[`SSR_PIN_W-2];
	assign addr_s   = pins_s[`SSR_ADDR_W-1:0];
	assign poll_win  = spoll_s & talk_s & (addr_s == my_addr);
	assign poll_done = s_q.poll_sel & ~poll_win;
	// Completion source follows the sweep mode; plot_done counts in every mode
	assign op_cond = ((s_q.sweep_mode != SSR_SW_MANUAL) & cond.sweep_end)
		| ((s_q.sweep_mode == SSR_SW_MANUAL) & cond.meas_done)
		| cond.plot_done;

	assign cond_now  = {cond.limit_fail, op_cond, cond.key_pressed,
		cond.data_ready, cond.syntax_error};
	assign cond_rise = {rise(cond_now[4], s_q.cond_prev[4]),
		rise(cond_now[3], s_q.cond_prev[3]),
		rise(cond_now[2], s_q.cond_prev[2]),
		rise(cond_now[1], s_q.cond_prev[1]),
		rise(cond_now[0], s_q.cond_prev[0])};

	assign clr_op_lim = cmd.sweep_continuous_select | cmd.sweep_single_select
		| cmd.sweep_manual_select | cmd.knob_manual_frequency | cmd.trace_a_clear
		| cmd.state_recall | cmd.plot_command | cmd.plot_marker_command;
	always_comb begin
		set_bits = 8'h00;
		if (cond_rise[0]) begin
			set_bits = set_bits | ssr_bit(`SSR_BIT_SYNTAX);
		end
		if (cond_rise[1]) begin
			set_bits = set_bits | ssr_bit(`SSR_BIT_DREADY);
		end
		if (cond_rise[2] && s_q.key_echo_req) begin
			set_bits = set_bits | ssr_bit(`SSR_BIT_KEY);
		end
		if (cond_rise[3] && s_q.opdone_en) begin
			set_bits = set_bits | ssr_bit(`SSR_BIT_OPDONE);
		end
		if (cond_rise[4] && s_q.limit_mode == SSR_LIM_REQ) begin
			set_bits = set_bits | ssr_bit(`SSR_BIT_LIMIT);
		end
		if (set_bits != 8'h00) begin
			set_bits = set_bits | ssr_bit(`SSR_BIT_RQS);
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.cond_prev     = cond_now;
		s_d.sweep_restart = 1'b0;
		s_d.data_go       = 1'b0;
		s_d.wr_en         = 1'b0;

		// Status byte: clears first, new events win over them
		if (poll_done || cmd.instrument_preset) begin
			s_d.status = `SSR_STATUS_RESET;
		end
		if (clr_op_lim) begin
			s_d.status[`SSR_BIT_OPDONE] = 1'b0;
			s_d.status[`SSR_BIT_LIMIT]  = 1'b0;
		end
		s_d.status = s_d.status | set_bits;
		s_d.status[`SSR_BIT_SPARE5] = 1'b0;
		s_d.status[`SSR_BIT_SPARE7] = 1'b0;

		// Serial poll: byte is captured as the device becomes selected
		s_d.poll_sel = poll_win;
		s_d.dio_oe   = poll_win;
		if (poll_win && !s_q.poll_sel) begin
			s_d.dio = s_q.status;
		end

		// Request enables
		if (cmd.opdone_request_on) begin
			s_d.opdone_en = 1'b1;
		end else if (cmd.opdone_request_off) begin
			s_d.opdone_en = 1'b0;
		end
		if (cmd.limit_test_with_request) begin
			s_d.limit_mode = SSR_LIM_REQ;
		end else if (cmd.limit_test_silent) begin
			s_d.limit_mode = SSR_LIM_SILENT;
		end else if (cmd.limit_test_off) begin
			s_d.limit_mode = SSR_LIM_OFF;
		end
		if (cmd.key_echo_with_request) begin
			s_d.key_echo_req = 1'b1;
		end else if (cmd.key_echo_clear) begin
			s_d.key_echo_req = 1'b0;
		end

		// Sweep mode selection
		if (cmd.sweep_continuous_select) begin
			s_d.sweep_mode = SSR_SW_CONT;
		end else if (cmd.sweep_manual_select) begin
			s_d.sweep_mode = SSR_SW_MANUAL;
		end else if (cmd.sweep_single_select) begin
			if (s_q.sweep_mode == SSR_SW_SINGLE) begin
				s_d.sweep_restart = 1'b1;
			end else begin
				s_d.sweep_mode = SSR_SW_SINGLE;
			end
		end

		// Zero reference; the full 10-bit range is legal
		if (cmd.zero_ref_write) begin
			s_d.zero_ref = zero_ref_in;
		end else if (cmd.state_recall) begin
			s_d.zero_ref = recall_zero_ref;
		end
		if (draw_start) begin
			s_d.draw_ref = s_q.zero_ref;
		end

		// Triggered data answer
		if (data_req) begin
			s_d.data_pend = 1'b1;
		end
		if (s_d.data_pend && (marker_valid || !s_q.opdone_en)) begin
			s_d.data_go   = 1'b1;
			s_d.data_pend = 1'b0;
		end

		// Outgoing words: trace dump and extended status
		if (!s_q.tx_valid || tx_ready) begin
			s_d.tx_valid = 1'b0;
			unique case (s_q.dump)
				SSR_DMP_IDLE: begin
				end
				SSR_DMP_FLAG: begin
					s_d.tx_word  = `SSR_FLAG_WORD;
					s_d.tx_valid = 1'b1;
					s_d.idx      = 10'h000;
					s_d.dump     = SSR_DMP_DATA;
				end
				SSR_DMP_DATA: begin
					s_d.tx_word  = mem_rd_data;
					s_d.tx_valid = 1'b1;
					if (s_q.idx == `SSR_TRACE_LAST) begin
						s_d.dump = SSR_DMP_IDLE;
					end else begin
						s_d.idx = s_q.idx + 10'h001;
					end
				end
				SSR_DMP_EXT: begin
					s_d.tx_word  = {6'h00, autorange_busy, autorange_busy, 8'h00};
					s_d.tx_valid = 1'b1;
					s_d.dump     = SSR_DMP_IDLE;
				end
			endcase
		end
		if (s_q.dump == SSR_DMP_IDLE) begin
			if (cmd.trace_memory_dump) begin
				s_d.dump    = SSR_DMP_FLAG;
				s_d.mem_reg = zero_ref_in[3:0];
			end else if (cmd.extended_status_dump) begin
				s_d.dump = SSR_DMP_EXT;
			end
		end

		// Incoming trace load: flag word first, then the data words
		if (cmd.trace_memory_load && !s_q.load_act) begin
			s_d.load_act  = 1'b1;
			s_d.flag_seen = 1'b0;
			s_d.widx      = 10'h000;
			s_d.mem_reg   = zero_ref_in[3:0];
		end else if (s_q.load_act && rx_valid) begin
			if (!s_q.flag_seen) begin
				s_d.flag_seen = (rx_word == `SSR_FLAG_WORD);
			end else begin
				s_d.wr_en   = 1'b1;
				s_d.wr_addr = s_q.widx;
				s_d.wr_data = rx_word;
				s_d.widx    = s_q.widx + 10'h001;
				if (s_q.widx == `SSR_TRACE_LAST) begin
					s_d.load_act = 1'b0;
				end
			end
		end

		// Synchronous preset of zero reference, request enables and pending data request
		if (cmd.instrument_preset) begin
			s_d.zero_ref     = `SSR_ZREF_DEFAULT;
			s_d.opdone_en    = 1'b0;
			s_d.limit_mode   = SSR_LIM_OFF;
			s_d.key_echo_req = 1'b0;
			s_d.data_pend    = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_q            <= '0;
			s_q.zero_ref   <= `SSR_ZREF_DEFAULT;
			s_q.draw_ref   <= `SSR_ZREF_DEFAULT;
			s_q.sweep_mode <= SSR_SW_CONT;
			s_q.limit_mode <= SSR_LIM_OFF;
			s_q.dump       <= SSR_DMP_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign srq_out       = s_q.status[`SSR_BIT_RQS];
	assign dio_out       = s_q.dio;
	assign dio_oe        = s_q.dio_oe;
	assign status_byte   = s_q.status;
	assign zero_ref      = s_q.zero_ref;
	assign draw_zero_ref = s_q.draw_ref;
	assign limit_test_en = (s_q.limit_mode != SSR_LIM_OFF);
	assign sweep_mode    = s_q.sweep_mode;
	assign sweep_restart = s_q.sweep_restart;
	assign data_go       = s_q.data_go;
	assign mem_reg       = s_q.mem_reg;
	assign mem_rd_idx    = s_q.idx;
	assign mem_wr_en     = s_q.wr_en;
	assign mem_wr_idx    = s_q.wr_addr;
	assign mem_wr_data   = s_q.wr_data;
	assign tx_word       = s_q.tx_word;
	assign tx_valid      = s_q.tx_valid;
	assign rx_ready      = s_q.load_act;

	a_srq_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(srq_out && !poll_done && !cmd.instrument_preset) |=> srq_out)
		else $error("request line dropped without poll or preset");
	a_spare_bits_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!status_byte[5] && !status_byte[7])
		else $error("unused status bit set");
	a_any_sets_rqs: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(set_bits != 8'h00) |=> status_byte[6] && srq_out)
		else $error("event without service request");
	a_poll_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(poll_done && set_bits == 8'h00) |=> status_byte == 8'h00)
		else $error("status not cleared after poll");
	a_level_no_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(cond.syntax_error && $past(cond.syntax_error) && poll_done)
		|=> !status_byte[0])
		else $error("held condition set its bit again");
	a_opdone_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!s_q.opdone_en && !status_byte[3] && !clr_op_lim) |=> !status_byte[3])
		else $error("op complete bit set while disabled");
	a_limit_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(s_q.limit_mode != SSR_LIM_REQ && !status_byte[4]) |=> !status_byte[4])
		else $error("limit bit set without request mode");
	a_drive_only_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
		dio_oe |-> $past(poll_win))
		else $error("bus driven outside serial poll");
	a_poll_shows_byte: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(poll_win && !s_q.poll_sel) |=> dio_oe && dio_out == $past(status_byte))
		else $error("poll byte not status byte");
	a_single_restart: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(cmd.sweep_single_select && !cmd.sweep_continuous_select
		&& !cmd.sweep_manual_select)
		|=> sweep_restart == ($past(sweep_mode) == SSR_SW_SINGLE)
		&& sweep_mode == SSR_SW_SINGLE)
		else $error("single sweep restart wrong");
	a_preset_zref: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cmd.instrument_preset |=> zero_ref == 10'h1F4)
		else $error("preset did not restore zero reference");
	a_flag_first: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(s_q.dump == SSR_DMP_FLAG && (!tx_valid || tx_ready))
		|=> tx_valid && tx_word == 16'hFFFF)
		else $error("trace dump did not start with flag");
	a_marker_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(data_go && $past(s_q.opdone_en)) |-> $past(marker_valid))
		else $error("data answered before marker valid");
endmodule

`default_nettype wire

/* File: testbench/ssr_ctrl_model.sv */
// Bus controller model: serial polls, trace-load words, tx stalls.
// Assumes its tasks are called at falling edges of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module ssr_ctrl_model (
	input  wire logic        clk_sys,        // System clock
	input  wire logic [7:0]  dio_out,        // Bus data
	input  wire logic        dio_oe,         // Block drives bus
	input  wire logic        rx_ready,       // Block takes word
	output logic             spoll_pin,      // Serial poll mode
	output logic             talk_pin,       // Talk addressed
	output logic [4:0]       poll_addr_pin,  // Polled address
	output logic             tx_ready,       // Takes tx word
	output logic [15:0]      rx_word,        // Word to block
	output logic             rx_valid,       // Word valid
	output logic [8:0]       poll_res,       // Answered, byte
	output logic             poll_seen       // Result pulse
);
	int seed = 77;
	initial begin
		{spoll_pin, talk_pin, poll_addr_pin, rx_valid, poll_seen} = '0;
		{rx_word, poll_res} = '0;
	end
	// Random stalls on the outgoing channel
	always @(negedge clk_sys) tx_ready <= ($random(seed) & 3) != 0;
	// Poll, read the whole byte at once, then deselect
	task automatic serial_poll(input logic [4:0] a, input logic t);
		int n;
		poll_res = '0;
		{spoll_pin, talk_pin, poll_addr_pin} = {1'b1, t, a};
		for (n = 0; n < 8 && dio_oe !== 1'b1; n++) @(negedge clk_sys);
		if (dio_oe === 1'b1) poll_res = {1'b1, dio_out};
		{spoll_pin, talk_pin, poll_addr_pin} = {2'b00, ~a};
		for (n = 0; n < 8 && dio_oe !== 1'b0; n++) @(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
		poll_seen = 1'b1;
		@(negedge clk_sys);
		poll_seen = 1'b0;
	endtask
	// Word held until taken at a rising edge
	task automatic send_word(input logic [15:0] w);
		int n;
		{rx_valid, rx_word} = {1'b1, w};
		@(posedge clk_sys);
		for (n = 0; n < 20 && rx_ready !== 1'b1; n++) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic rx_idle();
		{rx_valid, rx_word} = {1'b0, ~rx_word};
	endtask
endmodule
`default_nettype wire

/* File: testbench/status_service_request_tb_top.sv */
// Self-checking bench of the status and service-request block.
// Assumes ssr_ctrl_model stands in for the bus controller.
`timescale 1ns/100ps
`default_nettype none
`include "ssr_params.svh"
module status_service_request_tb_top
	import ssr_pkg::*;
;
	localparam int C_PRE = 19, C_OPON = 18, C_OPOFF = 17, C_LREQ = 16;
	localparam int C_LSIL = 15, C_LOFF = 14, C_ECHO = 13, C_ECLR = 12, C_SSING = 10, C_SMAN = 9;
	localparam int C_RCL = 6, C_EXT = 3, C_DUMP = 2, C_LOAD = 1, C_ZW = 0;
	logic        clk_sys, rst_b, draw_start, autorange_busy, data_req, marker_valid;
	ssr_cmd_t    cmd;
	ssr_cond_t   cond;
	ssr_sweep_t  sweep_mode;
	logic [9:0]  zero_ref_in, recall_zero_ref, zero_ref, draw_zero_ref, zv;
	logic [9:0]  mem_rd_idx, mem_wr_idx;
	logic [4:0]  my_addr, poll_addr_pin;
	logic        spoll_pin, talk_pin, srq_out, dio_oe, limit_test_en;
	logic        sweep_restart, data_go, mem_wr_en, tx_valid, tx_ready;
	logic        rx_valid, rx_ready, poll_seen;
	logic [7:0]  dio_out, status_byte;
	logic [3:0]  mem_reg;
	logic [15:0] mem_rd_data, mem_wr_data, tx_word, rx_word;
	logic [8:0]  poll_res;
	logic [8:0]  poll_q[$];
	logic [15:0] tx_q[$];
	logic [25:0] wr_q[$];
	int          fails = 0, tests_run = 0, seed = 77, go_n = 0, rs_n = 0, i;
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	assign mem_rd_data = {mem_reg, 2'b00, mem_rd_idx};
	ssr_top ssr_top_i (.clk_sys, .rst_b, .cmd, .cond, .zero_ref_in, .recall_zero_ref,
		.draw_start, .autorange_busy, .data_req, .marker_valid, .my_addr, .spoll_pin,
		.talk_pin, .poll_addr_pin, .srq_out, .dio_out, .dio_oe, .status_byte, .zero_ref,
		.draw_zero_ref, .limit_test_en, .sweep_mode, .sweep_restart, .data_go, .mem_reg,
		.mem_rd_idx, .mem_rd_data, .mem_wr_en, .mem_wr_idx, .mem_wr_data, .tx_word,
		.tx_valid, .tx_ready, .rx_word, .rx_valid, .rx_ready);
	ssr_ctrl_model ssr_ctrl_model_i (.clk_sys, .dio_out, .dio_oe, .rx_ready, .spoll_pin,
		.talk_pin, .poll_addr_pin, .tx_ready, .rx_word, .rx_valid, .poll_res, .poll_seen);
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic pulse(input int b);
		cmd = ssr_cmd_t'(20'h1 << b);
		tick(1);
		cmd = '0;
		tick(1);
	endtask
	task automatic blip(input int b);
		cond[b] = 1'b1;
		tick(1);
		cond[b] = 1'b0;
		tick(2);
	endtask
	task automatic poll(input logic [4:0] a, input logic t, input logic [8:0] e);
		poll_q.push_back(e);
		ssr_ctrl_model_i.serial_poll(a, t);
	endtask
	task automatic drain();
		for (int n = 0; n < 3000 && tx_q.size() > 0; n++) tick(1);
		tick(2);
	endtask
	task automatic req();
		data_req = 1'b1;
		tick(1);
		data_req = 1'b0;
	endtask
	// Result monitor: oldest note against each result
	always @(posedge clk_sys) begin
		if (poll_seen === 1'b1)
			check("poll", poll_res, poll_q.pop_front());
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			check("tx_word", tx_word, tx_q.pop_front());
		if (mem_wr_en === 1'b1)
			check("mem_wr", {mem_wr_idx, mem_wr_data}, wr_q.pop_front());
		if (data_go === 1'b1) go_n++;
		if (sweep_restart === 1'b1) rs_n++;
	end
	initial begin
		#400000;
		fails++;
		conclude();
	end
	initial begin
		{rst_b, draw_start, autorange_busy, data_req, marker_valid} = '0;
		{cmd, cond, zero_ref_in, recall_zero_ref} = '0;
		my_addr = 5'h0B;
		tick(4);
		rst_b = 1'b1;
		check("reset", {srq_out, dio_oe, limit_test_en, status_byte}, 11'h000);
		check("zref", zero_ref, `SSR_ZREF_DEFAULT);
		check("sweep", sweep_mode, SSR_SW_CONT);
		tick(3);
		cond.syntax_error = 1'b1;
		tick(3);
		check("status", {srq_out, status_byte}, 9'h141);
		poll(my_addr, 1'b1, 9'h141);
		check("status", {srq_out, status_byte}, 9'h000);
		cond.syntax_error = 1'b0;
		blip(5);
		blip(4);
		check("status", status_byte, 8'h42);
		pulse(C_ECHO);
		blip(4);
		poll(my_addr, 1'b1, 9'h146);
		pulse(C_ECLR);
		blip(4);
		blip(6);
		poll(~my_addr, 1'b1, 9'h000);
		poll(my_addr, 1'b0, 9'h000);
		check("srq", {srq_out, status_byte}, 9'h141);
		poll(my_addr, 1'b1, 9'h141);
		pulse(C_OPON);
		blip(3);
		check("status", status_byte, 8'h48);
		for (i = 4; i < 12; i++) begin
			recall_zero_ref = 10'($random(seed));
			blip(1);
			check("opdone", status_byte[3], 1'b1);
			pulse(i);
			check("clear", {srq_out, status_byte}, 9'h140);
			if (i == C_RCL) zv = recall_zero_ref;
			if (i == C_RCL) check("recall", zero_ref, zv);
		end
		poll(my_addr, 1'b1, 9'h140);
		pulse(C_SMAN);
		blip(3);
		check("manual", status_byte, 8'h00);
		blip(2);
		check("manual", status_byte, 8'h48);
		poll(my_addr, 1'b1, 9'h148);
		pulse(C_OPOFF);
		blip(3);
		check("status", status_byte, 8'h00);
		pulse(C_LREQ);
		blip(0);
		check("limit", {limit_test_en, status_byte}, 9'h150);
		poll(my_addr, 1'b1, 9'h150);
		pulse(C_LSIL);
		blip(0);
		check("silent", {limit_test_en, srq_out, status_byte}, 10'h200);
		pulse(C_LOFF);
		check("off", limit_test_en, 1'b0);
		pulse(C_SSING);
		check("single", {sweep_mode, 2'(rs_n)}, {SSR_SW_SINGLE, 2'd0});
		pulse(C_SSING);
		check("restart", rs_n, 1);
		pulse(C_OPON);
		req();
		tick(5);
		check("hold", go_n, 0);
		marker_valid = 1'b1;
		tick(3);
		check("go", go_n, 1);
		pulse(C_OPOFF);
		marker_valid = 1'b0;
		req();
		tick(3);
		check("go", go_n, 2);
		draw_start = 1'b1;
		tick(1);
		draw_start = 1'b0;
		zero_ref_in = `SSR_ZREF_MAX;
		pulse(C_ZW);
		check("zref", {zero_ref, draw_zero_ref}, {`SSR_ZREF_MAX, zv});
		draw_start = 1'b1;
		tick(1);
		draw_start = 1'b0;
		tick(1);
		check("draw", draw_zero_ref, `SSR_ZREF_MAX);
		blip(6);
		pulse(C_PRE);
		check("preset", {zero_ref, srq_out, status_byte}, {`SSR_ZREF_DEFAULT, 9'h0});
		autorange_busy = 1'b1;
		tx_q.push_back(16'h0300);
		pulse(C_EXT);
		drain();
		autorange_busy = 1'b0;
		tx_q.push_back(16'h0000);
		pulse(C_EXT);
		drain();
		zero_ref_in = 10'h005;
		tx_q.push_back(`SSR_FLAG_WORD);
		for (i = 0; i < 1001; i++) tx_q.push_back({4'h5, 2'b00, 10'(i)});
		pulse(C_DUMP);
		drain();
		check("dump", tx_q.size(), 0);
		zero_ref_in = 10'h006;
		for (i = 0; i < 1001; i++) wr_q.push_back({10'(i), 16'(i * 3)});
		pulse(C_LOAD);
		check("mem_reg", mem_reg, 4'h6);
		ssr_ctrl_model_i.send_word(16'h1234);
		ssr_ctrl_model_i.send_word(`SSR_FLAG_WORD);
		for (i = 0; i < 1001; i++) ssr_ctrl_model_i.send_word(16'(i * 3));
		ssr_ctrl_model_i.rx_idle();
		tick(4);
		check("load", {rx_ready, 11'(wr_q.size())}, 12'h000);
		conclude();
	end
endmodule
`default_nettype wire
